// ### heater_current_alarms.sv
// Heater current short/leak and overcurrent alarm logic with APB registers
// Contract
// - Short/leak alarm evaluated only while heating output is off, above threshold.
// - Cooling outputs never drive short/leak evaluation.
// - Off intervals of 100 ms or less are skipped for short/leak.
// - Short/leak threshold 0.1..99.9 A, default 100.0; 0.0 forces on, 100.0 off.
// - Both alarms apply hysteresis 0.1..100.0 A, default 0.1.
// - Hysteresis writable only when stopped; takes effect after software reset.
// - Read-only leakage current monitor, 0.0..110.0 A.
// - Short/leak alarm never stops temperature control.
// - Short/leak latch setting keeps alarm on; changeable only while stopped.
// - Latched short/leak released by error reset, software reset, power, or 100.0 write.
// - Overcurrent alarm evaluated only while heating output on, above threshold.
// - Cooling outputs never drive overcurrent evaluation.
// - On intervals of 100 ms or less are skipped for overcurrent.
// - Overcurrent threshold 0.1..99.9 A, default 100.0; 0.0 forces on, 100.0 off.
// - Read-only heater current monitor, 0.0..110.0 A.
// - Overcurrent alarm never stops temperature control.
// - Overcurrent latch setting keeps alarm on after current returns.
// - Latched overcurrent released by error reset, software reset, power, or 100.0 write.
// - Alarms work only with a current input present and assigned.
// - Input assignment 0 disabled or 1..4 output; changeable only while stopped.
//
// The APB slave port and the register offsets were decided locally.
`default_nettype none
module heater_current_alarms #(
  parameter int MIN_PHASE_CYCLES = heater_alarm_pkg::MIN_PHASE_CYC
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Current transformer measurement, 0.1 A units
  input  wire logic        ct_present,
  input  wire logic        ct_valid,
  input  wire logic [10:0] ct_current,
  // Control outputs: level and heating/cooling role
  input  wire logic [3:0]  ctrl_out_on,
  input  wire logic [3:0]  ctrl_out_heating,
  // Alarm outputs
  output logic             short_leak_alarm,
  output logic             over_current_alarm
);

  // Settings
  logic        running;
  logic        sl_latch_en;
  logic        oc_latch_en;
  logic [2:0]  ct_assign;
  logic [10:0] sl_thr;
  logic [10:0] oc_thr;
  logic [10:0] sl_hys_pend;
  logic [10:0] oc_hys_pend;
  logic [10:0] sl_hys;
  logic [10:0] oc_hys;
  logic [10:0] leak_mon;
  logic [10:0] heat_mon;
  logic [31:0] next_prdata;

  // Phase tracking
  logic        out_on;
  logic        out_prev;
  logic        assigned_heat;
  logic [31:0] phase_cnt;
  logic        phase_long;

  logic        wr_en;
  logic        rd_en;
  logic        err_reset;
  logic        sw_reset;
  logic        sl_thr_off_wr;
  logic        oc_thr_off_wr;

  // Write decode
  logic        ctrl_wr;
  logic        ctrl_wr_stopped;
  logic        thr_word_ok;
  logic        hys_word_ok;
  logic        phase_edge;

  // Alarm terms
  logic        path_ok;
  logic        sl_clear;
  logic        oc_clear;
  logic        sl_sample;
  logic        oc_sample;
  logic        sl_release;
  logic        oc_release;

  // Saturate a measured value at the monitor ceiling
  function automatic logic [10:0] clip_mon(input logic [10:0] v);
    clip_mon = (v > heater_alarm_pkg::CUR_MON_MAX) ? heater_alarm_pkg::CUR_MON_MAX : v;
  endfunction

  // Accept only 0.0, 100.0 or 0.1..99.9; others are ignored
  function automatic logic thr_ok(input logic [10:0] v);
    thr_ok = (v <= heater_alarm_pkg::CUR_FORCE_OFF);
  endfunction

  // Hysteresis range 0.1..100.0
  function automatic logic hys_ok(input logic [10:0] v);
    hys_ok = (v >= heater_alarm_pkg::HYS_MIN) && (v <= heater_alarm_pkg::CUR_FORCE_OFF);
  endfunction

  // Assignment codes 0..4 only
  function automatic logic assign_ok(input logic [2:0] v);
    assign_ok = (v <= 3'h4);
  endfunction

  // Current plus hysteresis at or below threshold; a spare bit keeps the sum from wrapping
  function automatic logic below_release(input logic [10:0] cur, input logic [10:0] hys, input logic [10:0] thr);
    below_release = ({1'b0, cur} + {1'b0, hys}) <= {1'b0, thr};
  endfunction

  // Bit of a per-output vector picked by assignment code 1..4
  function automatic logic pick_output(input logic [3:0] v, input logic [2:0] code);
    pick_output = v[code[1:0] - 2'h1];
  endfunction

  // One-cycle APB access, no wait states
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;

  assign err_reset = wr_en && (paddr == heater_alarm_pkg::ADDR_CMD) && pwdata[heater_alarm_pkg::CMD_ERR_RESET];
  assign sw_reset  = wr_en && (paddr == heater_alarm_pkg::ADDR_CMD) && pwdata[heater_alarm_pkg::CMD_SW_RESET];
  assign sl_thr_off_wr = wr_en && (paddr == heater_alarm_pkg::ADDR_SL_THR)
                         && (pwdata[10:0] == heater_alarm_pkg::CUR_FORCE_OFF);
  assign oc_thr_off_wr = wr_en && (paddr == heater_alarm_pkg::ADDR_OC_THR)
                         && (pwdata[10:0] == heater_alarm_pkg::CUR_FORCE_OFF);

  // Control word writes; stopped-only fields need running low
  assign ctrl_wr         = wr_en && (paddr == heater_alarm_pkg::ADDR_CTRL);
  assign ctrl_wr_stopped = ctrl_wr && !running;

  // Range checks on written words; reserved bits must be zero
  assign thr_word_ok = thr_ok(pwdata[10:0]) && (pwdata[31:11] == 21'h000000);
  assign hys_word_ok = hys_ok(pwdata[10:0]) && (pwdata[31:11] == 21'h000000);

  // Run flag; power-up and software reset both leave the unit stopped
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || sw_reset)
      running <= 1'b0;
    else if (ctrl_wr)
      running <= pwdata[heater_alarm_pkg::CTRL_RUN_BIT];
  end

  // Latch settings; frozen while running so behaviour cannot shift mid-run
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || sw_reset)
    begin
      sl_latch_en <= 1'b0;
      oc_latch_en <= 1'b0;
    end
    else if (ctrl_wr_stopped)
    begin
      sl_latch_en <= pwdata[heater_alarm_pkg::CTRL_SL_LATCH];
      oc_latch_en <= pwdata[heater_alarm_pkg::CTRL_OC_LATCH];
    end
  end

  // Input assignment; codes above 4 are ignored rather than wrapped
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || sw_reset)
      ct_assign <= heater_alarm_pkg::ASSIGN_RESET;
    else if (ctrl_wr_stopped && assign_ok(pwdata[heater_alarm_pkg::CTRL_ASSIGN_LO +: 3]))
      ct_assign <= pwdata[heater_alarm_pkg::CTRL_ASSIGN_LO +: 3];
  end

  // Short/leak threshold; may change at any time, bad words keep the old value
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || sw_reset)
      sl_thr <= heater_alarm_pkg::THR_RESET;
    else if (wr_en && paddr == heater_alarm_pkg::ADDR_SL_THR && thr_word_ok)
      sl_thr <= pwdata[10:0];
  end

  // Overcurrent threshold; same rules as the short/leak one
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || sw_reset)
      oc_thr <= heater_alarm_pkg::THR_RESET;
    else if (wr_en && paddr == heater_alarm_pkg::ADDR_OC_THR && thr_word_ok)
      oc_thr <= pwdata[10:0];
  end

  // Pending short/leak hysteresis; written only while stopped, survives software reset
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      sl_hys_pend <= heater_alarm_pkg::HYS_RESET;
    else if (wr_en && !running && paddr == heater_alarm_pkg::ADDR_SL_HYS && hys_word_ok)
      sl_hys_pend <= pwdata[10:0];
  end

  // Pending overcurrent hysteresis
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      oc_hys_pend <= heater_alarm_pkg::HYS_RESET;
    else if (wr_en && !running && paddr == heater_alarm_pkg::ADDR_OC_HYS && hys_word_ok)
      oc_hys_pend <= pwdata[10:0];
  end

  // Live short/leak hysteresis; power-up sees default, software reset adopts the pending value
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      sl_hys <= heater_alarm_pkg::HYS_RESET;
    else if (sw_reset)
      sl_hys <= sl_hys_pend;
  end

  // Live overcurrent hysteresis
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      oc_hys <= heater_alarm_pkg::HYS_RESET;
    else if (sw_reset)
      oc_hys <= oc_hys_pend;
  end

  // Select the assigned output; only a heating output qualifies
  always_comb
  begin
    out_on        = 1'b0;
    assigned_heat = 1'b0;
    if (ct_present && ct_assign != 3'h0 && ct_assign <= 3'h4)
    begin
      out_on        = pick_output(ctrl_out_on, ct_assign);
      assigned_heat = pick_output(ctrl_out_heating, ct_assign);
    end
  end

  // Phase length counter; saturates so long phases stay qualified
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      out_prev  <= 1'b0;
      phase_cnt <= 32'h0000_0000;
    end
    else
    begin
      out_prev <= out_on;
      if (phase_edge)
        phase_cnt <= 32'h0000_0000;
      else if (!phase_long)
        phase_cnt <= phase_cnt + 32'h0000_0001;
    end
  end

  // A level change restarts the count
  assign phase_edge = (out_on != out_prev);

  // The count still holds the old phase at the change edge, so that edge is never qualified
  assign phase_long = !phase_edge && (phase_cnt >= 32'(MIN_PHASE_CYCLES));

  // Heater current monitor; on-phase samples of a heating output only
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      heat_mon <= 11'h000;
    else if (ct_present && ct_valid && assigned_heat && out_on)
      heat_mon <= clip_mon(ct_current);
  end

  // Leakage current monitor; off-phase samples of a heating output only
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      leak_mon <= 11'h000;
    else if (ct_present && ct_valid && assigned_heat && !out_on)
      leak_mon <= clip_mon(ct_current);
  end

  // Alarm qualification; the path must exist, be assigned and drive a heater
  assign path_ok    = ct_present && (ct_assign != 3'h0) && assigned_heat;
  assign sl_sample  = !out_on && phase_long && ct_valid;
  assign oc_sample  = out_on && phase_long && ct_valid;
  assign sl_release = below_release(ct_current, sl_hys, sl_thr);
  assign oc_release = below_release(ct_current, oc_hys, oc_thr);

  // Release actions win over a set in the same cycle
  assign sl_clear = sw_reset || err_reset || sl_thr_off_wr;
  assign oc_clear = sw_reset || err_reset || oc_thr_off_wr;

  // Short/leak alarm: off phase, rises above threshold, falls at or below threshold less hysteresis
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || sl_clear)
      short_leak_alarm <= 1'b0;
    else if (!path_ok)
      short_leak_alarm <= 1'b0;
    else if (sl_thr == heater_alarm_pkg::CUR_FORCE_ON)
      short_leak_alarm <= 1'b1;
    else if (sl_thr == heater_alarm_pkg::CUR_FORCE_OFF)
      short_leak_alarm <= 1'b0;
    else if (sl_sample)
    begin
      if (ct_current > sl_thr)
        short_leak_alarm <= 1'b1;
      else if (!sl_latch_en && sl_release)
        short_leak_alarm <= 1'b0;
    end
  end

  // Overcurrent alarm: on phase, mirrors the short/leak structure
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || oc_clear)
      over_current_alarm <= 1'b0;
    else if (!path_ok)
      over_current_alarm <= 1'b0;
    else if (oc_thr == heater_alarm_pkg::CUR_FORCE_ON)
      over_current_alarm <= 1'b1;
    else if (oc_thr == heater_alarm_pkg::CUR_FORCE_OFF)
      over_current_alarm <= 1'b0;
    else if (oc_sample)
    begin
      if (ct_current > oc_thr)
        over_current_alarm <= 1'b1;
      else if (!oc_latch_en && oc_release)
        over_current_alarm <= 1'b0;
    end
  end

  // Alarms are status only; nothing here gates control outputs, so a
  // heater that trips either alarm keeps being regulated

  // Read mux
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      heater_alarm_pkg::ADDR_CTRL:
        next_prdata = {25'h0, ct_assign, 1'b0, oc_latch_en, sl_latch_en, running};
      // Command bits are strobes and read back as zero
      heater_alarm_pkg::ADDR_CMD:      next_prdata = 32'h0000_0000;
      heater_alarm_pkg::ADDR_STATUS:
        next_prdata = {29'h0, phase_long, over_current_alarm, short_leak_alarm};
      heater_alarm_pkg::ADDR_SL_THR:   next_prdata = {21'h0, sl_thr};
      heater_alarm_pkg::ADDR_OC_THR:   next_prdata = {21'h0, oc_thr};
      heater_alarm_pkg::ADDR_SL_HYS:   next_prdata = {21'h0, sl_hys_pend};
      heater_alarm_pkg::ADDR_OC_HYS:   next_prdata = {21'h0, oc_hys_pend};
      heater_alarm_pkg::ADDR_LEAK_MON: next_prdata = {21'h0, leak_mon};
      heater_alarm_pkg::ADDR_HEAT_MON: next_prdata = {21'h0, heat_mon};
      default:                         next_prdata = 32'h0000_0000;
    endcase
  end

  // Read data registered in the setup cycle, valid in the access cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      prdata <= 32'h0000_0000;
    else if (rd_en)
      prdata <= next_prdata;
  end

endmodule // heater_current_alarms
`default_nettype wire

// ### heater_alarm_pkg.sv
// Package: constants for the heater current alarm block
`default_nettype none
package heater_alarm_pkg;
  // Current values in units of 0.1 A
  localparam int CUR_W = 11;
  localparam logic [10:0] CUR_FORCE_ON  = 11'h000;  // 0.0 A
  localparam logic [10:0] CUR_FORCE_OFF = 11'h3E8;  // 100.0 A
  localparam logic [10:0] CUR_MON_MAX   = 11'h44C;  // 110.0 A
  localparam logic [10:0] THR_RESET     = 11'h3E8;  // Threshold default 100.0
  localparam logic [10:0] HYS_RESET     = 11'h001;  // Hysteresis default 0.1
  localparam logic [10:0] HYS_MIN       = 11'h001;
  // Timing
  localparam int CLK_HZ        = 125000000;
  localparam int MIN_PHASE_MS  = 100;
  localparam int MIN_PHASE_CYC = (CLK_HZ / 1000) * MIN_PHASE_MS;
  // Register offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CMD      = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_SL_THR   = 8'h10;
  localparam logic [7:0] ADDR_OC_THR   = 8'h14;
  localparam logic [7:0] ADDR_SL_HYS   = 8'h18;
  localparam logic [7:0] ADDR_OC_HYS   = 8'h1C;
  localparam logic [7:0] ADDR_LEAK_MON = 8'h20;
  localparam logic [7:0] ADDR_HEAT_MON = 8'h24;
  // Control register fields
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_SL_LATCH  = 1;
  localparam int CTRL_OC_LATCH  = 2;
  localparam int CTRL_ASSIGN_LO = 4;
  localparam logic [2:0] ASSIGN_RESET = 3'h1;
  // Command register bits
  localparam int CMD_ERR_RESET = 0;
  localparam int CMD_SW_RESET  = 1;
endpackage
`default_nettype wire

// ### heater_alarms_monitor.sv
// Checker for the heater current alarm ports
`default_nettype none
module heater_alarms_monitor (
  // Clock, reset and bus answer
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic pready,
  input wire logic pslverr,
  // Measurement and alarms
  input wire logic ct_present,
  input wire logic short_leak_alarm,
  input wire logic over_current_alarm
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  a_ready_no_wait: assert property (pready && !pslverr)
    else $error("bus answer not immediate or error flagged");
  a_sl_reset_clear: assert property ($rose(rstn) |-> !short_leak_alarm)
    else $error("short leak alarm set out of reset");
  a_oc_reset_clear: assert property ($rose(rstn) |-> !over_current_alarm ##1 !over_current_alarm)
    else $error("overcurrent alarm set out of reset");
  a_sl_needs_ct: assert property ($rose(short_leak_alarm) |-> $past(ct_present))
    else $error("short leak alarm rose without a current input");
  a_oc_needs_ct: assert property ($rose(over_current_alarm) |-> $past(ct_present, 1))
    else $error("overcurrent alarm rose without a current input");
  a_ct_loss_sl: assert property (!ct_present [*2] |-> !short_leak_alarm)
    else $error("short leak alarm held after input loss");
  a_ct_loss_oc: assert property (!ct_present ##1 !ct_present |-> !over_current_alarm)
    else $error("overcurrent alarm held after input loss");
  a_sl_oc_quiet: assert property ($fell(ct_present) |=> !short_leak_alarm && !over_current_alarm)
    else $error("alarm still set one cycle after input loss");
endmodule // heater_alarms_monitor
bind heater_current_alarms heater_alarms_monitor u_mon (.sys_clk(sys_clk), .rstn(rstn), .pready(pready),
  .pslverr(pslverr), .ct_present(ct_present), .short_leak_alarm(short_leak_alarm),
  .over_current_alarm(over_current_alarm));
`default_nettype wire

// ### ct_model.sv
// Behavioural current transformer feeding the alarm block
`default_nettype none
module ct_model (
  // Clock and stimulus from the bench
  input  wire logic        sys_clk,
  input  wire logic        present,
  input  wire logic [10:0] amps,
  // Measurement path
  output logic             ct_present = 1'b0,
  output logic             ct_valid = 1'b0,
  output logic      [10:0] ct_current = 11'h000
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] tick = 2'h0;
  // Sample every fourth cycle; a missing sensor toggles so no stale value passes
  always @(posedge sys_clk)
  begin
    tick <= tick + 2'h1;
    ct_present <= present;
    ct_valid <= present && (tick == 2'h3);
    ct_current <= present ? amps : ~ct_current;
  end
endmodule // ct_model
`default_nettype wire

// ### heater_current_alarms_tb_top.sv
// Self-checking bench for the heater current alarm block
`default_nettype none
module heater_current_alarms_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CTRL = heater_alarm_pkg::ADDR_CTRL;
  localparam logic [7:0] CMD = heater_alarm_pkg::ADDR_CMD;
  localparam logic [7:0] SLT = heater_alarm_pkg::ADDR_SL_THR;
  localparam logic [7:0] OCT = heater_alarm_pkg::ADDR_OC_THR;
  localparam logic [7:0] SLH = heater_alarm_pkg::ADDR_SL_HYS;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, ct_present, ct_valid, sl, oc;
  logic [10:0] ct_current;
  logic [10:0] amps = 11'h000;
  logic        present = 1'b1;
  logic [3:0]  out_on = 4'h0;
  logic [3:0]  heat = 4'hF;
  int          errors = 0;
  int          checked = 0;
  int          cycles = 0;
  // Clock at 125 MHz
  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end
  heater_current_alarms #(.MIN_PHASE_CYCLES(20)) u_dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ct_present(ct_present), .ct_valid(ct_valid), .ct_current(ct_current),
    .ctrl_out_on(out_on), .ctrl_out_heating(heat), .short_leak_alarm(sl), .over_current_alarm(oc));
  ct_model u_ct (.sys_clk(sys_clk), .present(present), .amps(amps), .ct_present(ct_present),
    .ct_valid(ct_valid), .ct_current(ct_current));
  // Hang guard, far above the expected run
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors = errors + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // One transfer, held until pready is sampled high; idle cycles after let results land
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk("register", q, e);
  endtask
  // Heating output level and load current held for n cycles
  task automatic st(input logic on, input logic [10:0] a, input int n);
    out_on <= {3'h0, on};
    amps <= a;
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic al(input logic es, input logic eo);
    chk("short_leak_alarm", sl, {31'h0, es});
    chk("over_current_alarm", oc, {31'h0, eo});
  endtask
  // Main sequence
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rd(SLT, 32'h3E8);
    rd(OCT, 32'h3E8);
    rd(SLH, 32'h1);
    rd(heater_alarm_pkg::ADDR_OC_HYS, 32'h1);
    rd(8'h3C, 32'h0);
    wr(CTRL, 32'h11);
    wr(SLT, 32'h32);
    st(1'b1, 11'h03C, 30);
    st(1'b0, 11'h03C, 10);
    st(1'b1, 11'h03C, 4);
    al(1'b0, 1'b0);
    st(1'b0, 11'h03C, 30);
    al(1'b1, 1'b0);
    rd(heater_alarm_pkg::ADDR_STATUS, 32'h5);
    rd(heater_alarm_pkg::ADDR_LEAK_MON, 32'h3C);
    st(1'b0, 11'h032, 12);
    al(1'b1, 1'b0);
    st(1'b0, 11'h031, 12);
    al(1'b0, 1'b0);
    wr(SLT, 32'h0);
    al(1'b1, 1'b0);
    wr(SLT, 32'h3E8);
    al(1'b0, 1'b0);
    heat <= 4'h0;
    wr(SLT, 32'h32);
    st(1'b0, 11'h03C, 30);
    al(1'b0, 1'b0);
    heat <= 4'hF;
    wr(CTRL, 32'h10);
    wr(CTRL, 32'h12);
    wr(CTRL, 32'h13);
    st(1'b0, 11'h03C, 30);
    st(1'b0, 11'h000, 30);
    al(1'b1, 1'b0);
    wr(CMD, 32'h1);
    al(1'b0, 1'b0);
    st(1'b0, 11'h03C, 12);
    wr(SLT, 32'h3E8);
    al(1'b0, 1'b0);
    wr(CTRL, 32'h10);
    wr(CTRL, 32'h14);
    wr(CTRL, 32'h15);
    wr(OCT, 32'h50);
    st(1'b1, 11'h05A, 30);
    al(1'b0, 1'b1);
    rd(heater_alarm_pkg::ADDR_HEAT_MON, 32'h5A);
    st(1'b1, 11'h000, 30);
    al(1'b0, 1'b1);
    wr(CMD, 32'h2);
    al(1'b0, 1'b0);
    wr(SLH, 32'hA);
    wr(CTRL, 32'h11);
    wr(SLH, 32'h5);
    rd(SLH, 32'hA);
    wr(SLT, 32'h32);
    st(1'b0, 11'h03C, 30);
    st(1'b0, 11'h02D, 12);
    al(1'b0, 1'b0);
    wr(CMD, 32'h2);
    wr(CTRL, 32'h11);
    wr(SLT, 32'h32);
    st(1'b0, 11'h03C, 30);
    st(1'b0, 11'h02D, 12);
    al(1'b1, 1'b0);
    st(1'b0, 11'h028, 12);
    al(1'b0, 1'b0);
    st(1'b0, 11'h03C, 12);
    present <= 1'b0;
    st(1'b0, 11'h03C, 12);
    al(1'b0, 1'b0);
    present <= 1'b1;
    wr(CTRL, 32'h0);
    wr(CTRL, 32'h1);
    st(1'b0, 11'h03C, 30);
    al(1'b0, 1'b0);
    give_verdict();
  end
endmodule // heater_current_alarms_tb_top
`default_nettype wire
